// File: inc/nvi_pkg.sv
// Purpose: types of the two-wire memory target
// Assumes: nvi_regs.svh on the include path
// Notes: one struct per clock domain
`include "nvi_regs.svh"
package nvi_pkg;
    typedef enum logic [2:0] {
        S_IDLE, S_DEVADDR, S_ADDR_HI, S_ADDR_LO, S_WRITE, S_READ, S_IGNORE
    } nvi_state_type;
    typedef struct packed {
        logic scl_m, scl_s, scl_p;
        logic sda_m, sda_s, sda_p;
        logic wp_m, wp_s;
        logic [1:0] sel_m, sel_s;
        nvi_state_type st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic drive, nack, hs, busy, mem_sel, fresh, a16, wr_tgl;
        logic [7:0] hi_addr;
        logic [`NVI_MEM_AW-1:0] mem_addr;
        logic [7:0] ctrl_addr;
        logic [7:0] memctl;
        logic [7:0][7:0] serial;
        logic [7:0] cmd;
    } nvi_link_type;
    typedef struct packed {
        logic busy_m, busy_s, hs_m, hs_s;
        logic tgl_m, tgl_s, tgl_p, strobe;
    } nvi_core_type;
endpackage

// File: inc/nvi_regs.svh
// Purpose: constants of the two-wire memory target
// Assumes: included by the package and the design
// Notes: control target offsets are byte addresses on the link
`ifndef NVI_REGS_SVH
`define NVI_REGS_SVH
`define NVI_MEM_AW 17
`define NVI_FUNC_MEM 4'ha
`define NVI_FUNC_CTRL 4'h3
`define NVI_MASTER_CODE 5'h01
`define NVI_LAST_BIT 4'h7
`define NVI_ACK_SLOT 4'h8
`define NVI_START_CNT 4'hf
`define NVI_REG_MEMCTL 8'h00
`define NVI_REG_SN_FIRST 8'h01
`define NVI_REG_SN_LAST 8'h08
`define NVI_REG_ID_FIRST 8'h09
`define NVI_REG_ID_LAST 8'h0c
`define NVI_REG_CMD 8'haa
`define NVI_SNL_MASK 8'h40
`define NVI_BP_MASK 8'h0c
`define NVI_MEMCTL_RST 8'h00
`define NVI_CMD_RST 8'h00
`endif

// File: testbench/nvi_bus_master.sv
// Purpose: bus master model that drives scl and its own share of sda
// Assumes: stepped on falling edges of core_clk, sda pulled up outside
// Notes: 16 core cycles a quarter bit keeps each scl phase above 5 link cycles
`timescale 1ns/1ps
`default_nettype none
module nvi_bus_master (
    input wire logic core_clk,
    input wire logic sda,
    output var logic scl,
    output var logic sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic qwait(input int n);
        repeat (n * 16) @(negedge core_clk);
    endtask
    // start and repeated start, scl left low
    task automatic start();
        sda_drv = 1'b1;
        qwait(1);
        scl = 1'b1;
        qwait(2);
        sda_drv = 1'b0;
        qwait(2);
        scl = 1'b0;
        qwait(1);
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        qwait(1);
        scl = 1'b1;
        qwait(2);
        sda_drv = 1'b1;
        qwait(2);
    endtask
    // sampled late in the high phase so the target has settled
    task automatic bit_io(input logic b, output logic got);
        sda_drv = b;
        qwait(1);
        scl = 1'b1;
        qwait(2);
        got = sda;
        scl = 1'b0;
        qwait(1);
    endtask
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic nak;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], nak);
        end
        bit_io(1'b1, nak);
        ack = ~nak;
    endtask
    task automatic read_byte(input logic more, output logic [7:0] d);
        logic x;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(~more, x);
    endtask
endmodule // nvi_bus_master
`default_nettype wire

// File: testbench/nvi_target_test.sv
// Purpose: self-checking bench of the two-wire memory target
// Assumes: nvi_bus_master as far side, pull-up on sda
// Notes: memory tracked in a shadow array; only written bytes are read back
`timescale 1ns/1ps
`default_nettype none
module nvi_target_test;
    localparam logic [31:0] DEV_ID = 32'h3c5a_9612; // arbitrary value
    logic core_clk, link_clk, sys_rst, write_protect, ack;
    logic [1:0] sel;
    logic [7:0] d;
    logic [16:0] cur, base;
    wire logic scl, sda_drv, sda_out, sda_oe_n, bus_busy, high_speed, write_strobe;
    wire logic sda = sda_drv & (sda_oe_n | sda_out);
    int seed = 47531;
    int miscompares = 0;
    int tests_run = 0;
    int ws_cnt = 0;
    int ws_exp = 0;
    int n;
    logic [7:0] shadow [0:131071];

    nvi_target #(.DEVICE_ID(DEV_ID)) u_dut (
        .core_clk(core_clk),
        .link_clk(link_clk),
        .sys_rst(sys_rst),
        .scl_in(scl),
        .sda_in(sda),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .write_protect(write_protect),
        .target_select_pins(sel),
        .bus_busy(bus_busy),
        .high_speed(high_speed),
        .write_strobe(write_strobe)
    );
    nvi_bus_master u_bus (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        link_clk = 1'b0;
        #37;
        forever #80 link_clk = ~link_clk;
    end
    always @(posedge core_clk) begin
        if (write_strobe === 1'b1) ws_cnt <= ws_cnt + 1;
    end

    task automatic check_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s: got %b want %b", $time, what, got, exp);
        end
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic send(input logic [7:0] b, input logic exp_ack);
        u_bus.write_byte(b, ack);
        check_bit(ack, exp_ack, "ack");
    endtask
    task automatic set_addr(input logic [16:0] a);
        u_bus.start();
        send({4'ha, sel, a[16], 1'b0}, 1'b1);
        send(a[15:8], 1'b1);
        send(a[7:0], 1'b1);
    endtask
    task automatic finish_frame();
        u_bus.stop();
        repeat (40) @(negedge core_clk);
        check_bit(bus_busy, 1'b0, "busy");
        check_byte(8'(ws_cnt), 8'(ws_exp), "strobes");
    endtask
    task automatic write_burst(input logic [16:0] a, input int cnt);
        set_addr(a);
        check_bit(bus_busy, 1'b1, "busy");
        for (int i = 0; i < cnt; i++) begin
            d = 8'($random(seed));
            send(d, ~write_protect);
            if (!write_protect) begin
                shadow[a] = d;
                ws_exp++;
            end
            a++; // 17-bit wrap
        end
        cur = a;
        finish_frame();
    endtask
    task automatic read_burst(input logic [16:0] a, input int cnt, input logic rnd);
        if (rnd) set_addr(a);
        else a = cur;
        u_bus.start();
        send({4'ha, sel, 2'b01}, 1'b1);
        for (int i = 0; i < cnt; i++) begin
            u_bus.read_byte(i != cnt - 1, d);
            check_byte(d, shadow[a], "read");
            a++;
        end
        cur = a;
        repeat (8) @(negedge core_clk);
        check_bit(sda_oe_n, 1'b1, "release");
        finish_frame();
    endtask
    task automatic test_done();
        if (miscompares == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        // at most about 110 bytes of 576 cycles each, plus frame gaps
        repeat (90000) @(posedge core_clk);
        miscompares++;
        test_done();
    end

    initial begin
        sys_rst = 1'b1;
        write_protect = 1'b0;
        sel = 2'($random(seed));
        // reset is asynchronous; one link edge still falls inside it
        repeat (3) @(negedge core_clk);
        sys_rst = 1'b0;
        check_bit(bus_busy, 1'b0, "busy");
        check_bit(high_speed, 1'b0, "hs");
        check_bit(sda_oe_n, 1'b1, "idle");
        repeat (20) @(negedge core_clk);
        u_bus.start();
        send({4'ha, ~sel, 2'b00}, 1'b0);
        send(8'h00, 1'b0);
        u_bus.start();
        send({4'h5, sel, 2'b00}, 1'b0);
        write_burst(17'h0_0040, 2);
        u_bus.start();
        for (int i = 0; i < 3; i++) u_bus.bit_io(1'b1, ack);
        write_burst(17'h1_fffe, 3);
        read_burst(17'h1_fffe, 3, 1'b1);
        repeat (3) begin
            base = 17'($random(seed));
            n = 1 + ($unsigned($random(seed)) % 3);
            write_burst(base, 2 * n);
            read_burst(base, n, 1'b1);
            read_burst(base, n, 1'b0);
        end
        write_protect = 1'b1;
        repeat (20) @(negedge core_clk);
        write_burst(base, 1);
        write_protect = 1'b0;
        read_burst(base, 1, 1'b1);
        u_bus.start();
        send(8'h08 | 8'($random(seed) & 7), 1'b0);
        set_addr(base);
        d = 8'($random(seed));
        send(d, 1'b1);
        shadow[base] = d;
        ws_exp++;
        u_bus.start();
        check_bit(high_speed, 1'b1, "hs");
        finish_frame();
        check_bit(high_speed, 1'b0, "hs");
        read_burst(base, 1, 1'b1);
        u_bus.start();
        send({4'h3, sel, 2'b10}, 1'b1);
        send(8'h09, 1'b1);
        u_bus.start();
        send({4'h3, sel, 2'b01}, 1'b1);
        for (int i = 0; i < 4; i++) begin
            u_bus.read_byte(i != 3, d);
            check_byte(d, DEV_ID[8*i +: 8], "id");
        end
        finish_frame();
        u_bus.start();
        send({4'h3, sel, 2'b00}, 1'b1);
        send(8'h0a, 1'b1);
        send(8'($random(seed)), 1'b0);
        finish_frame();
        test_done();
    end
endmodule // nvi_target_test
`default_nettype wire

// File: verilog/nvi_target.sv
// Purpose: two-wire target of a byte-wide memory with a control register target
// Assumes: link_clk oversamples scl and sda; sys_rst asynchronous, active high
// Notes: link logic on link_clk, status crosses into core_clk
`timescale 1ns/1ps
`default_nettype none
`include "nvi_regs.svh"
module nvi_target #(
    parameter logic [31:0] DEVICE_ID = 32'h5a5a_0001 // arbitrary value
) (
    input wire logic core_clk,
    input wire logic link_clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic write_protect,
    input wire logic [1:0] target_select_pins,
    output logic bus_busy,
    output logic high_speed,
    output logic write_strobe
);
    localparam int DEPTH = 2 ** `NVI_MEM_AW;
    localparam logic [3:0][7:0] ID_BYTES = DEVICE_ID;

    nvi_pkg::nvi_link_type r, n;
    nvi_pkg::nvi_core_type c, cn;
    logic [7:0] mem_array [DEPTH];
    logic mem_we;
    logic scl_rise, scl_fall, start_c, stop_c;
    logic [7:0] rd_data;
    logic [`NVI_MEM_AW-1:0] rd_mem;
    logic [7:0] rd_ctrl;

    function automatic logic [7:0] nvi_ctrl_read(
        input logic [7:0] a,
        input logic [7:0] mc,
        input logic [7:0][7:0] sn
    );
        logic [7:0] off;
        logic [7:0] res;
        off = 8'h00;
        res = 8'h00;
        if (a == `NVI_REG_MEMCTL) begin
            res = mc;
        end else if (a >= `NVI_REG_SN_FIRST && a <= `NVI_REG_SN_LAST) begin
            off = a - `NVI_REG_SN_FIRST;
            res = sn[off[2:0]];
        end else if (a >= `NVI_REG_ID_FIRST && a <= `NVI_REG_ID_LAST) begin
            off = a - `NVI_REG_ID_FIRST;
            res = ID_BYTES[off[1:0]];
        end
        return res;
    endfunction

    // open drain: the output level is always low
    assign sda_out = 1'b0;
    assign sda_oe_n = ~r.drive;

    always_comb begin
        n = r;
        mem_we = 1'b0;
        rd_mem = r.mem_addr;
        rd_ctrl = r.ctrl_addr;
        rd_data = 8'h00;
        n.scl_m = scl_in;
        n.scl_s = r.scl_m;
        n.scl_p = r.scl_s;
        n.sda_m = sda_in;
        n.sda_s = r.sda_m;
        n.sda_p = r.sda_s;
        n.wp_m = write_protect;
        n.wp_s = r.wp_m;
        n.sel_m = target_select_pins;
        n.sel_s = r.sel_m;
        scl_rise = r.scl_s & ~r.scl_p;
        scl_fall = ~r.scl_s & r.scl_p;
        start_c = r.scl_s & r.scl_p & r.sda_p & ~r.sda_s;
        stop_c = r.scl_s & r.scl_p & ~r.sda_p & r.sda_s;
        if (start_c) begin
            // repeated start too: abort and wait for an address byte
            n.st = nvi_pkg::S_DEVADDR;
            // scl falls once after start before any bit: that fall wraps this to zero
            n.cnt = `NVI_START_CNT;
            n.drive = 1'b0;
            n.nack = 1'b0;
            n.busy = 1'b1;
        end else if (stop_c) begin
            n.st = nvi_pkg::S_IDLE;
            n.cnt = 4'h0;
            n.drive = 1'b0;
            n.busy = 1'b0;
            n.hs = 1'b0;
        end else if (r.st != nvi_pkg::S_IDLE && r.st != nvi_pkg::S_IGNORE) begin
            if (scl_rise) begin
                if (r.cnt == `NVI_ACK_SLOT) begin
                    n.nack = r.sda_s;
                end else if (r.st != nvi_pkg::S_READ) begin
                    n.sh = {r.sh[6:0], r.sda_s};
                end
            end
            if (scl_fall) begin
                if (r.cnt == `NVI_LAST_BIT) begin
                    n.cnt = `NVI_ACK_SLOT;
                    n.drive = 1'b0;
                    case (r.st)
                        nvi_pkg::S_DEVADDR: begin
                            if (r.sh[7:3] == `NVI_MASTER_CODE) begin
                                // master code is never acknowledged
                                n.hs = 1'b1;
                                n.st = nvi_pkg::S_IGNORE;
                            end else if (r.sh[3:2] == r.sel_s &&
                                (r.sh[7:4] == `NVI_FUNC_MEM ||
                                 r.sh[7:4] == `NVI_FUNC_CTRL)) begin
                                n.drive = 1'b1;
                                n.mem_sel = (r.sh[7:4] == `NVI_FUNC_MEM);
                                if (r.sh[0]) begin
                                    n.st = nvi_pkg::S_READ;
                                    n.fresh = 1'b1;
                                end else begin
                                    n.a16 = r.sh[1];
                                    n.st = (r.sh[7:4] == `NVI_FUNC_MEM) ?
                                        nvi_pkg::S_ADDR_HI : nvi_pkg::S_ADDR_LO;
                                end
                            end else begin
                                n.st = nvi_pkg::S_IGNORE;
                            end
                        end
                        nvi_pkg::S_ADDR_HI: begin
                            n.hi_addr = r.sh;
                            n.drive = 1'b1;
                            n.st = nvi_pkg::S_ADDR_LO;
                        end
                        nvi_pkg::S_ADDR_LO: begin
                            // a restart here gives a random read
                            n.drive = 1'b1;
                            n.st = nvi_pkg::S_WRITE;
                            // no advance in this ack slot: the address is not a data byte
                            n.fresh = 1'b1;
                            if (r.mem_sel) begin
                                n.mem_addr = {r.a16, r.hi_addr, r.sh};
                            end else begin
                                n.ctrl_addr = r.sh;
                            end
                        end
                        nvi_pkg::S_WRITE: begin
                            if (r.mem_sel) begin
                                if (r.wp_s) begin
                                    n.st = nvi_pkg::S_IGNORE;
                                end else begin
                                    mem_we = 1'b1;
                                    n.drive = 1'b1;
                                    n.wr_tgl = ~r.wr_tgl;
                                end
                            end else begin
                                n.drive = 1'b1;
                                if (r.ctrl_addr == `NVI_REG_MEMCTL) begin
                                    // lock bit can be set but never cleared
                                    n.memctl = (r.sh & `NVI_BP_MASK) |
                                        ((r.sh | r.memctl) & `NVI_SNL_MASK);
                                end else if (r.ctrl_addr >= `NVI_REG_SN_FIRST &&
                                    r.ctrl_addr <= `NVI_REG_SN_LAST &&
                                    (r.memctl & `NVI_SNL_MASK) == 8'h00) begin
                                    n.serial = nvi_write_sn(r.serial, r.ctrl_addr, r.sh);
                                end else if (r.ctrl_addr == `NVI_REG_CMD) begin
                                    n.cmd = r.sh;
                                end else begin
                                    n.drive = 1'b0;
                                    n.st = nvi_pkg::S_IGNORE;
                                end
                            end
                        end
                        default: begin
                            n.st = r.st;
                        end
                    endcase
                end else if (r.cnt == `NVI_ACK_SLOT) begin
                    n.cnt = 4'h0;
                    n.drive = 1'b0;
                    n.fresh = 1'b0;
                    if (r.st == nvi_pkg::S_READ) begin
                        // step past the byte just sent, even on a nack, so the
                        // next current-address read does not repeat it
                        if (!r.fresh) begin
                            if (r.mem_sel) begin
                                rd_mem = r.mem_addr + 17'h00001;
                            end else begin
                                rd_ctrl = r.ctrl_addr + 8'h01;
                            end
                        end
                        n.mem_addr = rd_mem;
                        n.ctrl_addr = rd_ctrl;
                        if (r.nack) begin
                            n.st = nvi_pkg::S_IGNORE;
                        end else begin
                            rd_data = r.mem_sel ? mem_array[rd_mem] :
                                nvi_ctrl_read(rd_ctrl, r.memctl, r.serial);
                            n.sh = rd_data;
                            n.drive = ~rd_data[7];
                        end
                    end else if (r.st == nvi_pkg::S_WRITE && r.drive && !r.fresh) begin
                        if (r.mem_sel) begin
                            n.mem_addr = r.mem_addr + 17'h00001;
                        end else begin
                            n.ctrl_addr = r.ctrl_addr + 8'h01;
                        end
                    end
                end else begin
                    n.cnt = r.cnt + 4'h1;
                    if (r.st == nvi_pkg::S_READ) begin
                        n.sh = {r.sh[6:0], 1'b0};
                        n.drive = ~r.sh[6];
                    end
                end
            end
        end
    end

    function automatic logic [7:0][7:0] nvi_write_sn(
        input logic [7:0][7:0] sn,
        input logic [7:0] a,
        input logic [7:0] d
    );
        logic [7:0] off;
        logic [7:0][7:0] res;
        res = sn;
        off = a - `NVI_REG_SN_FIRST;
        res[off[2:0]] = d;
        return res;
    endfunction

    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            r <= '{st: nvi_pkg::S_IDLE, cnt: 4'h0, sh: 8'h00,
                   memctl: `NVI_MEMCTL_RST, cmd: `NVI_CMD_RST,
                   scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
                   sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1, default: '0};
        end else begin
            r <= n;
        end
    end

    // array has no reset: contents persist like the real cells
    always_ff @(posedge link_clk) begin
        if (mem_we) begin
            mem_array[r.mem_addr] <= r.sh;
        end
    end

    // status into the core domain: levels by two flops, writes by toggle
    always_comb begin
        cn = c;
        cn.busy_m = r.busy;
        cn.busy_s = c.busy_m;
        cn.hs_m = r.hs;
        cn.hs_s = c.hs_m;
        cn.tgl_m = r.wr_tgl;
        cn.tgl_s = c.tgl_m;
        cn.tgl_p = c.tgl_s;
        cn.strobe = c.tgl_s ^ c.tgl_p;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            c <= '0;
        end else begin
            c <= cn;
        end
    end

    assign bus_busy = c.busy_s;
    assign high_speed = c.hs_s;
    assign write_strobe = c.strobe;

    default clocking @(posedge link_clk); endclocking
    default disable iff (sys_rst);

    start_resets_a: assert property (start_c |=>
        r.st == nvi_pkg::S_DEVADDR && r.cnt == `NVI_START_CNT && !r.drive)
        else $error("start did not reset the transfer");
    stop_idles_a: assert property (stop_c |=>
        r.st == nvi_pkg::S_IDLE && !r.hs && !r.busy)
        else $error("stop did not return to idle");
    never_high_a: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    ignore_quiet_a: assert property ((r.st == nvi_pkg::S_IGNORE && !start_c) |=>
        !r.drive)
        else $error("data pulled while ignoring");
    wp_nack_a: assert property ((scl_fall && r.cnt == 4'h7 && r.st == nvi_pkg::S_WRITE
        && r.mem_sel && r.wp_s && !start_c && !stop_c) |=> !r.drive && !mem_we)
        else $error("protected write acknowledged");
    addr_inc_a: assert property ((scl_fall && r.cnt == 4'h8 && r.st == nvi_pkg::S_WRITE
        && r.drive && !r.fresh && r.mem_sel && !start_c && !stop_c) |=>
        r.mem_addr == $past(r.mem_addr) + 17'h00001)
        else $error("address not advanced after write");
    match_ack_a: assert property ((scl_fall && r.cnt == 4'h7
        && r.st == nvi_pkg::S_DEVADDR && r.sh[3:2] == r.sel_s && r.sh[7:4] == 4'ha
        && !start_c && !stop_c) |=> r.drive [*1] ##1 (r.drive || r.cnt == 4'h8))
        else $error("matching address not acknowledged");
    tx_release_a: assert property ((scl_fall && r.cnt == 4'h7
        && r.st == nvi_pkg::S_READ && !start_c && !stop_c) |=> !r.drive && r.cnt == 4'h8)
        else $error("transmitter kept the ack slot");
    read_nack_a: assert property ((scl_fall && r.cnt == 4'h8 && r.nack
        && r.st == nvi_pkg::S_READ && !start_c && !stop_c) |=>
        r.st == nvi_pkg::S_IGNORE && !r.drive)
        else $error("read went on after not-acknowledge");
    hs_enter_a: assert property ((scl_fall && r.cnt == 4'h7
        && r.st == nvi_pkg::S_DEVADDR && r.sh[7:3] == 5'h01 && !start_c && !stop_c) |=>
        r.hs && !r.drive)
        else $error("master code not taken");

    mem_write_c: cover property (mem_we && !r.wp_s);
    mem_read_c: cover property (r.st == nvi_pkg::S_READ && r.mem_sel && r.cnt == 4'h3);
    hs_mode_c: cover property (r.hs && start_c);
    ctrl_write_c: cover property (r.st == nvi_pkg::S_WRITE && !r.mem_sel && r.drive);
endmodule // nvi_target
`default_nettype wire
